/* File: design/rwc_pkg.sv */
`default_nettype none
package rwc_pkg;
   // ---------------------------------------------
   // register offsets
   // ---------------------------------------------
   localparam logic [7:0] ADR_CAL_HI   = 8'h94;
   localparam logic [7:0] ADR_CAL_LO   = 8'h95;
   localparam logic [7:0] ADR_COARSE   = 8'h96;
   localparam logic [7:0] ADR_PWD      = 8'h97;
   localparam logic [7:0] ADR_SYSSTATE = 8'hA1;
   localparam logic [7:0] ADR_TRD      = 8'hDA;
   localparam logic [7:0] ADR_DIV_HI   = 8'hDB;
   localparam logic [7:0] ADR_DIV_MID  = 8'hDC;
   localparam logic [7:0] ADR_DIV_LO   = 8'hDD;
   localparam logic [7:0] ADR_SECCFG   = 8'hDF;
   // ---------------------------------------------
   // field values
   // ---------------------------------------------
   localparam logic [7:0] PWD_UNLOCK   = 8'h57;
   localparam logic [7:0] PWD_LOCK     = 8'h56;
   localparam logic [2:0] COARSE_FINE  = 3'h7;
   localparam int         SEC_WE_BIT   = 6;
   localparam int         SYS_WAKE_BIT = 2;
   localparam logic [7:0] TRD_VALUE    = 8'h00;
   localparam logic [7:0] RST_BYTE     = 8'h00;
   // ---------------------------------------------
   // timing, in oscillator ticks or seconds
   // ---------------------------------------------
   localparam logic [16:0] OSC_PER_SEC  = 17'h08000;
   localparam logic [16:0] CAL_BASE     = 17'h08001;
   localparam logic [4:0]  CAL_LAST_SEC = 5'h1D;
   localparam logic [2:0]  WAKE_HOLD    = 3'h7;
   localparam logic [16:0] T_500MS      = 17'h04000;
   localparam logic [16:0] T_250MS      = 17'h02000;
   localparam logic [16:0] T_125MS      = 17'h01000;
   localparam logic [16:0] T_62MS5      = 17'h00800;
   localparam logic [16:0] T_1MIN       = 17'h0003C;
   localparam logic [16:0] T_1HOUR      = 17'h00E10;
   localparam logic [16:0] T_1DAY       = 17'h15180;
   localparam logic [16:0] T_1SEC       = 17'h00001;
endpackage
`default_nettype wire

/* File: design/rwc_top.sv */
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - wake interval is field plus one seconds for field 1 to 63
// - field zero with bit 6 set gives a fixed 62.5 ms wake interval; with bit 6 clear the coarse code picks it
// - clock wake reads status bit 2 set while pulse flag is clear
// - status bit and pulse flag both set means pulse ended sleep
// - 14-bit signed calibration value in high six and low eight bits
// - seconds 1 to 29 each end after 32768 oscillator ticks
// - thirtieth second ends at 32768 minus (C minus 1) ticks
// - step of 1.02 ppm, range about plus or minus 8332.3 ppm
// - time unlock register always reads 0x00
// - 24-bit divider threshold in three bytes, reset to zero
// - coarse code: 1s,1min,1h,1day,500ms,250ms,125ms,62.5ms
// - wake output held for eight oscillator periods
// - divider counts zero to threshold, clears, pulses, restarts
module rwc_top
   import rwc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   input  wire logic [7:0] sfr_wdata,
   input  wire logic       osc_pin,
   input  wire logic       sleep_active,
   input  wire logic       pulse_wake_flag,
   output logic [7:0]      sfr_rdata,
   output logic            wake_out,
   output logic            sec_pulse,
   output logic            div_pulse,
   output logic            time_rd_en
);
   // ---------------------------------------------
   // register file
   // ---------------------------------------------
   logic [7:0]  cal_hi_ff, cal_lo_ff, seccfg_ff;
   logic [2:0]  coarse_ff;
   logic        pwd_we_ff, wake_source_ff;
   logic [23:0] div_thr_ff;
   logic [7:0]  rdata_ff;
   logic        trd_ff;
   logic        wr_ok;
   logic        sec_wr_ok;

   assign wr_ok     = sfr_wr && pwd_we_ff;
   assign sec_wr_ok = seccfg_ff[SEC_WE_BIT] && (coarse_ff == COARSE_FINE);

   always_ff @(posedge clk) begin
      if (rst) begin
         pwd_we_ff <= 1'b0;
      end else if (sfr_wr && sfr_addr == ADR_PWD) begin
         if (sfr_wdata == PWD_UNLOCK) begin
            pwd_we_ff <= 1'b1;
         end else if (sfr_wdata == PWD_LOCK) begin
            pwd_we_ff <= 1'b0;
         end
      end
   end

   // calibration cleared on reset too, so cold start has known C
   always_ff @(posedge clk) begin
      if (rst) begin
         cal_hi_ff <= RST_BYTE;
         cal_lo_ff <= RST_BYTE;
         coarse_ff <= 3'h0;
      end else if (wr_ok) begin
         if (sfr_addr == ADR_CAL_HI) begin
            cal_hi_ff <= {2'h0, sfr_wdata[5:0]};
         end
         if (sfr_addr == ADR_CAL_LO) cal_lo_ff <= sfr_wdata;
         if (sfr_addr == ADR_COARSE) begin
            coarse_ff <= sfr_wdata[2:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         seccfg_ff <= RST_BYTE;
      end else if (sfr_wr && sfr_addr == ADR_SECCFG) begin
         seccfg_ff[7:6] <= sfr_wdata[7:6];
         if (sec_wr_ok) begin
            seccfg_ff[5:0] <= sfr_wdata[5:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         div_thr_ff <= 24'h000000;
      end else if (sfr_wr) begin
         if (sfr_addr == ADR_DIV_HI)  div_thr_ff[23:16] <= sfr_wdata;
         if (sfr_addr == ADR_DIV_MID) div_thr_ff[15:8]  <= sfr_wdata;
         if (sfr_addr == ADR_DIV_LO)  div_thr_ff[7:0]   <= sfr_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_ff <= RST_BYTE;
         trd_ff   <= 1'b0;
      end else begin
         trd_ff <= sfr_rd && (sfr_addr == ADR_TRD);
         if (sfr_rd) begin
            unique case (sfr_addr)
               ADR_CAL_HI:   rdata_ff <= cal_hi_ff;
               ADR_CAL_LO:   rdata_ff <= cal_lo_ff;
               ADR_COARSE:   rdata_ff <= {5'h00, coarse_ff};
               ADR_PWD:      rdata_ff <= {7'h00, pwd_we_ff};
               ADR_SYSSTATE: rdata_ff <= {5'h00, wake_source_ff, 2'h0};
               ADR_TRD:      rdata_ff <= TRD_VALUE;
               ADR_DIV_HI:   rdata_ff <= div_thr_ff[23:16];
               ADR_DIV_MID:  rdata_ff <= div_thr_ff[15:8];
               ADR_DIV_LO:   rdata_ff <= div_thr_ff[7:0];
               ADR_SECCFG:   rdata_ff <= seccfg_ff;
               default:      rdata_ff <= RST_BYTE;
            endcase
         end
      end
   end

   // ---------------------------------------------
   // oscillator sampling
   // ---------------------------------------------
   logic osc_s1_ff, osc_s2_ff, osc_s3_ff;
   logic osc_tick;

   always_ff @(posedge clk) begin
      if (rst) begin
         osc_s1_ff <= 1'b0;
         osc_s2_ff <= 1'b0;
         osc_s3_ff <= 1'b0;
      end else begin
         osc_s1_ff <= osc_pin;
         osc_s2_ff <= osc_s1_ff;
         osc_s3_ff <= osc_s2_ff;
      end
   end
   assign osc_tick = osc_s2_ff && !osc_s3_ff;

   // ---------------------------------------------
   // calibrated second generator
   // ---------------------------------------------
   logic [16:0] osc_cnt_ff, sec_thr;
   logic [4:0]  sec_idx_ff;
   logic [13:0] cal_lat_ff;
   logic        sec_end;

   // 30th second: 32768-(C-1); resolution 1/(32768*30) = 1.02 ppm
   assign sec_thr = (sec_idx_ff == CAL_LAST_SEC)
                  ? 17'(CAL_BASE - 17'(signed'(cal_lat_ff)))
                  : OSC_PER_SEC;
   assign sec_end = osc_tick && (osc_cnt_ff >= sec_thr - 17'h00001);

   always_ff @(posedge clk) begin
      if (rst) begin
         osc_cnt_ff <= 17'h00000;
         sec_idx_ff <= 5'h00;
         cal_lat_ff <= 14'h0000;
         sec_pulse  <= 1'b0;
      end else begin
         sec_pulse <= sec_end;
         if (sec_end) begin
            osc_cnt_ff <= 17'h00000;
            if (sec_idx_ff == CAL_LAST_SEC) begin
               sec_idx_ff <= 5'h00;
               cal_lat_ff <= {cal_hi_ff[5:0], cal_lo_ff};
            end else begin
               sec_idx_ff <= 5'(sec_idx_ff + 5'h01);
            end
         end else if (osc_tick) begin
            osc_cnt_ff <= 17'(osc_cnt_ff + 17'h00001);
         end
      end
   end

   // ---------------------------------------------
   // sleep wake timer
   // ---------------------------------------------
   logic [16:0] wk_cnt_ff, wk_thr;
   logic        wk_sub, wk_step, wk_fire;
   logic [2:0]  hold_ff;

   always_comb begin
      wk_sub = 1'b1;
      wk_thr = T_62MS5;
      if (seccfg_ff[5:0] != 6'h00) begin
         wk_sub = 1'b0;
         wk_thr = 17'({11'h000, seccfg_ff[5:0]} + 17'h00001);
      end else if (!seccfg_ff[SEC_WE_BIT]) begin
         // codes 4 to 7 count oscillator ticks, 0 to 3 whole seconds
         wk_sub = coarse_ff[2];
         unique case (coarse_ff)
            3'h0: wk_thr = T_1SEC;
            3'h1: wk_thr = T_1MIN;
            3'h2: wk_thr = T_1HOUR;
            3'h3: wk_thr = T_1DAY;
            3'h4: wk_thr = T_500MS;
            3'h5: wk_thr = T_250MS;
            3'h6: wk_thr = T_125MS;
            3'h7: wk_thr = T_62MS5;
         endcase
      end
   end
   assign wk_step = wk_sub ? osc_tick : sec_end;
   assign wk_fire = wk_step && (wk_cnt_ff >= wk_thr - 17'h00001);

   always_ff @(posedge clk) begin
      if (rst) begin
         wk_cnt_ff <= 17'h00000;
      end else if (!sleep_active || wk_fire) begin
         wk_cnt_ff <= 17'h00000;
      end else if (wk_step) begin
         wk_cnt_ff <= 17'(wk_cnt_ff + 17'h00001);
      end
   end

   // hold counts eight oscillator periods after the fire tick
   always_ff @(posedge clk) begin
      if (rst) begin
         wake_out <= 1'b0;
         hold_ff  <= 3'h0;
      end else if (sleep_active && wk_fire) begin
         wake_out <= 1'b1;
         hold_ff  <= WAKE_HOLD;
      end else if (wake_out && osc_tick) begin
         if (hold_ff == 3'h0) begin
            wake_out <= 1'b0;
         end else begin
            hold_ff <= 3'(hold_ff - 3'h1);
         end
      end
   end

   // status is set by either wake cause; software tells them apart
   // by also reading the pulse flag, so set wins over sleep entry
   always_ff @(posedge clk) begin
      if (rst) begin
         wake_source_ff <= 1'b0;
      end else if (sleep_active && (wk_fire || pulse_wake_flag)) begin
         wake_source_ff <= 1'b1;
      end else if (sleep_active && !wake_out) begin
         wake_source_ff <= 1'b0;
      end
   end

   // ---------------------------------------------
   // divider on the system clock
   // ---------------------------------------------
   logic [23:0] div_cnt_ff;

   always_ff @(posedge clk) begin
      if (rst) begin
         div_cnt_ff <= 24'h000000;
         div_pulse  <= 1'b0;
      end else if (div_cnt_ff >= div_thr_ff) begin
         div_cnt_ff <= 24'h000000;
         div_pulse  <= 1'b1;
      end else begin
         div_cnt_ff <= 24'(div_cnt_ff + 24'h000001);
         div_pulse  <= 1'b0;
      end
   end

   assign sfr_rdata  = rdata_ff;
   assign time_rd_en = trd_ff;

   // ---------------------------------------------
   // assertions
   // ---------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_trd_reads_zero: assert property (
      sfr_rd && sfr_addr == ADR_TRD |=> sfr_rdata == TRD_VALUE && time_rd_en)
      else $error("time unlock read not zero");
   a_sec_locked: assert property (
      sfr_wr && sfr_addr == ADR_SECCFG && !sec_wr_ok
      |=> $stable(seccfg_ff[5:0]))
      else $error("interval changed while locked");
   a_pwd_gates_cal: assert property (
      sfr_wr && !pwd_we_ff |=> $stable(cal_lo_ff) && $stable(cal_hi_ff))
      else $error("calibration written while locked");
   a_cal_hi_rsvd: assert property (
      cal_hi_ff[7:6] == 2'h0)
      else $error("calibration reserved bits set");
   a_sec_normal: assert property (
      sec_end && sec_idx_ff != CAL_LAST_SEC |-> osc_cnt_ff == 17'h07FFF)
      else $error("normal second not 32768 ticks");
   a_sec_last: assert property (
      sec_end && sec_idx_ff == CAL_LAST_SEC
      |-> 17'(osc_cnt_ff + 17'h00001) == sec_thr)
      else $error("calibrated second length wrong");
   a_wake_hold: assert property (
      $rose(wake_out) |-> wake_out [*8])
      else $error("wake output dropped early");
   a_div_wrap: assert property (
      div_cnt_ff >= div_thr_ff |=> div_pulse && div_cnt_ff == 24'h000000)
      else $error("divider did not wrap");
   a_wake_status: assert property (
      $rose(wake_out) |-> wake_source_ff)
      else $error("wake without status bit");

   c_wake: cover property (sleep_active && $rose(wake_out));
   c_cycle: cover property (sec_end && sec_idx_ff == CAL_LAST_SEC);
   c_div: cover property (div_pulse && div_thr_ff != 24'h000000);
   c_trd: cover property (time_rd_en);
endmodule
`default_nettype wire

/* File: testbench/rwc_top_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module rwc_top_bench
   import rwc_pkg::*;
;
   logic       clk             = 1'b0;
   logic       rst             = 1'b1;
   logic [7:0] sfr_addr        = 8'h00;
   logic       sfr_wr          = 1'b0;
   logic       sfr_rd          = 1'b0;
   logic [7:0] sfr_wdata       = 8'h00;
   logic       osc_pin         = 1'b0;
   logic       sleep_active    = 1'b0;
   logic       pulse_wake_flag = 1'b0;
   logic [7:0] sfr_rdata;
   logic       wake_out;
   logic       sec_pulse;
   logic       div_pulse;
   logic       time_rd_en;
   int         err_count       = 0;
   int         samples_checked = 0;
   int         osc_edges       = 0;
   logic [7:0] d;
   int         n;
   logic [7:0] rst_adr [9]     = '{ADR_CAL_HI, ADR_CAL_LO, ADR_SYSSTATE,
      ADR_TRD, ADR_DIV_HI, ADR_DIV_MID, ADR_DIV_LO, ADR_SECCFG, 8'h50};
   logic [7:0] thr_val [2]     = '{8'h03, 8'h05};

   rwc_top uut (
      .clk             (clk),
      .rst             (rst),
      .sfr_addr        (sfr_addr),
      .sfr_wr          (sfr_wr),
      .sfr_rd          (sfr_rd),
      .sfr_wdata       (sfr_wdata),
      .osc_pin         (osc_pin),
      .sleep_active    (sleep_active),
      .pulse_wake_flag (pulse_wake_flag),
      .sfr_rdata       (sfr_rdata),
      .wake_out        (wake_out),
      .sec_pulse       (sec_pulse),
      .div_pulse       (div_pulse),
      .time_rd_en      (time_rd_en)
   );

   // ---------------------------------------------
   // clock and oscillator
   // ---------------------------------------------
   always #12.5 clk = ~clk;

   // oscillator sped up to one period per two clocks so runs stay short
   always @(posedge clk) begin
      if (!rst) begin
         osc_pin <= ~osc_pin;
         if (!osc_pin) begin
            osc_edges <= osc_edges + 1;
         end
      end
   end

   // ---------------------------------------------
   // access and check tasks
   // ---------------------------------------------
   task automatic results();
      if (err_count == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic chk_rng(input int v, input int lo, input int hi);
      chk((v >= lo && v <= hi) ? lo : v, lo);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      sfr_addr  <= a;
      sfr_wdata <= v;
      sfr_wr    <= 1'b1;
      @(posedge clk);
      sfr_wr    <= 1'b0;
   endtask

   // read data is registered, so it is looked at after the taking edge
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      sfr_addr <= a;
      sfr_rd   <= 1'b1;
      @(posedge clk);
      sfr_rd   <= 1'b0;
      #1;
      v = sfr_rdata;
   endtask

   // counts clocks until the chosen output reaches the wanted level
   task automatic wait_sig(input int sel, input logic lvl, input int limit,
                           output int cnt);
      logic v;
      cnt = 0;
      v   = ~lvl;
      while (v !== lvl) begin
         @(posedge clk);
         #1;
         cnt++;
         case (sel)
            0: v = div_pulse;
            1: v = wake_out;
            default: v = sec_pulse;
         endcase
         if (cnt >= limit) begin
            err_count++;
            results();
         end
      end
   endtask

   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      foreach (rst_adr[i]) begin
         rd(rst_adr[i], d);
         chk(d, RST_BYTE);
      end
      wr(ADR_CAL_LO, 8'h5A);
      rd(ADR_CAL_LO, d);
      chk(d, 8'h00);
      wr(ADR_PWD, PWD_UNLOCK);
      wr(ADR_CAL_HI, 8'hFF);
      rd(ADR_CAL_HI, d);
      chk(d, 8'h3F);
      wr(ADR_CAL_LO, 8'h5A);
      rd(ADR_CAL_LO, d);
      chk(d, 8'h5A);
      // field refused until bit6 is stored and coarse code is 7
      wr(ADR_SECCFG, 8'h45);
      rd(ADR_SECCFG, d);
      chk(d, 8'h40);
      wr(ADR_SECCFG, 8'h45);
      rd(ADR_SECCFG, d);
      chk(d, 8'h40);
      wr(ADR_COARSE, {5'h00, COARSE_FINE});
      wr(ADR_SECCFG, 8'h45);
      rd(ADR_SECCFG, d);
      chk(d, 8'h45);
      wr(ADR_SECCFG, 8'h40);
      wr(ADR_PWD, PWD_LOCK);
      wr(ADR_CAL_LO, 8'h11);
      rd(ADR_CAL_LO, d);
      chk(d, 8'h5A);
      rd(ADR_TRD, d);
      chk(d, TRD_VALUE);
      chk({7'h00, time_rd_en}, 8'h01);
      @(posedge clk);
      #1;
      chk({7'h00, time_rd_en}, 8'h00);
      foreach (thr_val[i]) begin
         wr(ADR_DIV_HI, 8'h00);
         wr(ADR_DIV_MID, 8'h00);
         wr(ADR_DIV_LO, thr_val[i]);
         rd(ADR_DIV_LO, d);
         chk(d, thr_val[i]);
         wait_sig(0, 1'b0, 100, n);
         wait_sig(0, 1'b1, 100, n);
         wait_sig(0, 1'b0, 100, n);
         wait_sig(0, 1'b1, 100, n);
         chk(n, thr_val[i]);
      end
      // field zero with bit6 set: 2048 ticks of two clocks each
      @(posedge clk);
      sleep_active <= 1'b1;
      wait_sig(1, 1'b1, 5000, n);
      chk_rng(n, 4090, 4102);
      rd(ADR_SYSSTATE, d);
      chk(d[SYS_WAKE_BIT], 1'b1);
      // two clocks of the high time went to the status read
      wait_sig(1, 1'b0, 100, n);
      chk(n, 14);
      // still asleep with wake low, so the clock status clears
      rd(ADR_SYSSTATE, d);
      chk(d[SYS_WAKE_BIT], 1'b0);
      @(posedge clk);
      pulse_wake_flag <= 1'b1;
      rd(ADR_SYSSTATE, d);
      chk(d[SYS_WAKE_BIT], 1'b1);
      chk({7'h00, wake_out}, 8'h00);
      @(posedge clk);
      sleep_active    <= 1'b0;
      pulse_wake_flag <= 1'b0;
      // coarse code 6 with bit6 clear: 4096 ticks of two clocks each
      wr(ADR_PWD, PWD_UNLOCK);
      wr(ADR_COARSE, 8'h06);
      wr(ADR_SECCFG, 8'h00);
      rd(ADR_COARSE, d);
      chk(d, 8'h06);
      @(posedge clk);
      sleep_active <= 1'b1;
      wait_sig(1, 1'b1, 9000, n);
      chk_rng(n, 8186, 8198);
      @(posedge clk);
      sleep_active <= 1'b0;
      wait_sig(2, 1'b1, 70000, n);
      chk_rng(osc_edges, 32768, 32770);
      results();
   end
endmodule
`default_nettype wire
